/* hw/cmpf_map.svh */
`ifndef CMPF_MAP_SVH
`define CMPF_MAP_SVH
// Register addresses on the serial port (seven address bits).
`define CMPF_ADDR_FIFO 7'h00
`define CMPF_ADDR_OP_MODE 7'h01
`define CMPF_ADDR_SETUP_ONE 7'h10
`define CMPF_ADDR_SETUP_TWO 7'h11
`define CMPF_ADDR_PAYLOAD_LEN 7'h12
`define CMPF_ADDR_FRAME_CTRL 7'h13
`define CMPF_ADDR_RATE_HI 7'h14
`define CMPF_ADDR_RATE_LO 7'h15
`define CMPF_ADDR_FIFO_PTR 7'h16
`define CMPF_ADDR_SF6_TUNING 7'h31
`define CMPF_ADDR_SF6_THRESHOLD 7'h37
// Field positions.
`define CMPF_OP_SPREAD_BIT 7
`define CMPF_BW_MSB 7
`define CMPF_BW_LSB 4
`define CMPF_FEC_MSB 3
`define CMPF_FEC_LSB 1
`define CMPF_HEADERLESS_BIT 0
`define CMPF_SF_MSB 7
`define CMPF_SF_LSB 4
`define CMPF_CRC_ON_BIT 2
`define CMPF_START_BIT 0
// Reset values.
`define CMPF_RST_OP_MODE 8'h00
`define CMPF_RST_SETUP_ONE 8'h72
`define CMPF_RST_SETUP_TWO 8'h70
`define CMPF_RST_PAYLOAD_LEN 8'h00
`define CMPF_RST_SF6_REG 8'h00
// Limits and coding constants.
`define CMPF_SF_MIN 4'h6
`define CMPF_SF_MAX 4'hc
`define CMPF_FEC_MIN 3'h1
`define CMPF_FEC_MAX 3'h4
`define CMPF_HEADER_RATE 3'h4
`define CMPF_PREAMBLE_SYMBOLS 8'h0c
`define CMPF_CRC8_POLY 8'h07
`define CMPF_CRC16_POLY 16'h1021
// Timing: one chip lasts clock / bandwidth; the widest band sets the base.
`define CMPF_CLOCK_HZ 100000000
`define CMPF_WIDEST_BW_HZ 500000
`define CMPF_CHIP_BASE_CYCLES (`CMPF_CLOCK_HZ / `CMPF_WIDEST_BW_HZ)
`endif

/* hw/cmpf_pair_buffer.sv */
`timescale 1ns/10ps
module cmpf_pair_buffer
	import cmpf_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [12:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [12:0] out_data
);
	logic skid_valid;
	logic [12:0] skid_data;
	logic next_out_valid;
	logic next_skid_valid;
	logic [12:0] next_out_data;
	logic [12:0] next_skid_data;

	// Output stage plus one skid entry; ready is registered so the
	// producer never sees a combinational path from the consumer.
	always_comb begin
		next_out_valid = out_valid;
		next_out_data = out_data;
		next_skid_valid = skid_valid;
		next_skid_data = skid_data;
		if (!out_valid || out_ready) begin
			if (skid_valid) begin
				next_out_valid = 1'b1;
				next_out_data = skid_data;
				next_skid_valid = in_valid && in_ready;
				next_skid_data = in_data;
			end else begin
				next_out_valid = in_valid && in_ready;
				next_out_data = in_data;
			end
		end else if (in_valid && in_ready) begin
			next_skid_valid = 1'b1;
			next_skid_data = in_data;
		end
	end

	// Registers of the two entries.
	always_ff @(posedge clock) begin
		if (reset) begin
			out_valid <= 1'b0;
			out_data <= 13'h0000;
			skid_valid <= 1'b0;
			skid_data <= 13'h0000;
			in_ready <= 1'b0;
		end else begin
			out_valid <= next_out_valid;
			out_data <= next_out_data;
			skid_valid <= next_skid_valid;
			skid_data <= next_skid_data;
			in_ready <= !next_skid_valid;
		end
	end

	stall_hold_a: assert property (@(posedge clock) disable iff (reset)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("Stalled word changed or vanished.");
endmodule

/* hw/cmpf_pkg.sv */
package cmpf_pkg;
	typedef enum logic [1:0] {
		kind_preamble,
		kind_header,
		kind_payload,
		kind_crc
	} cmpf_kind_type;
	typedef enum logic [2:0] {
		st_idle,
		st_preamble,
		st_header,
		st_header_crc,
		st_payload,
		st_crc_hi,
		st_crc_lo
	} cmpf_state_type;
endpackage

/* hw/cmpf_spi_port.sv */
`timescale 1ns/10ps
`include "cmpf_map.svh"
module cmpf_spi_port
	import cmpf_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic sck,
	input wire logic nss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	output logic wr_strobe,
	output logic rd_strobe,
	output logic [6:0] reg_addr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	logic sck_prev;
	logic [2:0] bit_cnt;
	logic [7:0] in_shift;
	logic [7:0] out_shift;
	logic have_addr;
	logic is_write;
	logic load_due;
	logic [2:0] next_bit_cnt;
	logic [7:0] next_in_shift;
	logic [7:0] next_out_shift;
	logic next_have_addr;
	logic next_is_write;
	logic next_load_due;
	logic next_wr_strobe;
	logic next_rd_strobe;
	logic [6:0] next_reg_addr;
	logic [7:0] next_wr_data;
	logic rise;
	logic fall;
	logic [7:0] shifted;

	assign rise = sck && !sck_prev && !nss_n;
	assign fall = !sck && sck_prev && !nss_n;
	assign shifted = {in_shift[6:0], mosi};
	assign miso = out_shift[7];

	// Mode 0 framing: the first byte is write flag and address, then data
	// bytes follow. Reads prefetch one byte ahead, so the read that ends a
	// transfer still advances a data-buffer pointer.
	always_comb begin
		next_bit_cnt = bit_cnt;
		next_in_shift = in_shift;
		next_out_shift = out_shift;
		next_have_addr = have_addr;
		next_is_write = is_write;
		next_load_due = 1'b0;
		next_wr_strobe = 1'b0;
		next_rd_strobe = 1'b0;
		next_reg_addr = reg_addr;
		next_wr_data = wr_data;
		if (load_due) begin
			next_out_shift = rd_data;
		end
		// A write strobe must see the old address, so step on afterwards.
		if (wr_strobe && reg_addr != `CMPF_ADDR_FIFO) begin
			next_reg_addr = reg_addr + 7'h01;
		end
		if (nss_n) begin
			next_bit_cnt = 3'h0;
			next_have_addr = 1'b0;
		end else if (rise) begin
			next_in_shift = shifted;
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				if (!have_addr) begin
					next_have_addr = 1'b1;
					next_is_write = shifted[7];
					next_reg_addr = shifted[6:0];
					next_rd_strobe = !shifted[7];
					next_load_due = !shifted[7];
				end else begin
					if (!is_write
						&& reg_addr != `CMPF_ADDR_FIFO) begin
						next_reg_addr = reg_addr + 7'h01;
					end
					next_wr_strobe = is_write;
					next_rd_strobe = !is_write;
					next_load_due = !is_write;
					next_wr_data = shifted;
				end
			end
		end else if (fall && bit_cnt != 3'h0) begin
			next_out_shift = {out_shift[6:0], 1'b0};
		end
	end

	// Registers of the serial port; all decisions are made above.
	always_ff @(posedge clock) begin
		if (reset) begin
			sck_prev <= 1'b0;
			bit_cnt <= 3'h0;
			in_shift <= 8'h00;
			out_shift <= 8'h00;
			have_addr <= 1'b0;
			is_write <= 1'b0;
			load_due <= 1'b0;
			wr_strobe <= 1'b0;
			rd_strobe <= 1'b0;
			reg_addr <= 7'h00;
			wr_data <= 8'h00;
			miso_oe_n <= 1'b1;
		end else begin
			sck_prev <= sck;
			bit_cnt <= next_bit_cnt;
			in_shift <= next_in_shift;
			out_shift <= next_out_shift;
			have_addr <= next_have_addr;
			is_write <= next_is_write;
			load_due <= next_load_due;
			wr_strobe <= next_wr_strobe;
			rd_strobe <= next_rd_strobe;
			reg_addr <= next_reg_addr;
			wr_data <= next_wr_data;
			miso_oe_n <= nss_n;
		end
	end
endmodule

/* hw/cmpf_top.sv */
// Functional notes
// - Spread factor 6..12 gives 2^sf chips.
// - Rate codes 1..4 mean 4/5..4/8.
// - Coding rate travels inside the header.
// - Ten selectable bandwidths, 7.8 to 500 kHz.
// - Symbol rate equals bandwidth over 2^sf.
// - Bandwidth counts the whole double-sideband channel.
// - Packet: preamble, optional header, then payload.
// - Header holds length, rate, CRC presence.
// - Spread mode switches to its register map.
// - Dedicated dual-port data buffer behind serial port.
// - Header sent at rate 4/8 with CRC.
// - One bit selects explicit or headerless format.
`timescale 1ns/10ps
`include "cmpf_map.svh"
module cmpf_top
	import cmpf_pkg::*;
#(
	parameter logic [7:0] CHIP_BASE_CYCLES = 8'(`CMPF_CHIP_BASE_CYCLES)
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic sck,
	input wire logic nss_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe_n,
	output logic frame_valid,
	input wire logic frame_ready,
	output logic [1:0] frame_kind,
	output logic [2:0] frame_rate,
	output logic [7:0] frame_data
);
	logic wr_strobe;
	logic rd_strobe;
	logic [6:0] reg_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] op_mode, setup_one, setup_two, payload_len;
	logic [7:0] sf6_tuning, sf6_threshold, host_ptr, rd_ptr;
	logic [7:0] mem [0:255];
	cmpf_state_type state, next_state;
	logic [7:0] cnt, next_cnt, next_rd_ptr;
	logic [15:0] crc, next_crc;
	logic sym_due, next_sym_due;
	logic [7:0] base_cnt, next_base_cnt;
	logic [6:0] mult_cnt, next_mult_cnt;
	logic [12:0] chip_cnt, next_chip_cnt;
	logic spread_on, headerless, crc_on, busy, start, step;
	logic base_wrap, mult_wrap, chip_wrap, sym_tick;
	logic [3:0] sf_eff, bw_code;
	logic [2:0] cr_eff;
	logic [12:0] chips;
	logic [6:0] mult;
	logic [15:0] symbol_rate;
	logic push;
	cmpf_kind_type push_kind;
	logic [2:0] push_rate;
	logic [7:0] push_data;
	logic buf_in_ready;
	cmpf_state_type after_header;

	// Modem registers answer only while spread mode is selected.
	function automatic logic in_modem_map(input logic [6:0] a);
		in_modem_map = (a >= `CMPF_ADDR_SETUP_ONE
			&& a <= `CMPF_ADDR_FIFO_PTR) || a == `CMPF_ADDR_SF6_TUNING
			|| a == `CMPF_ADDR_SF6_THRESHOLD || a == `CMPF_ADDR_FIFO;
	endfunction

	// Clock cycles per chip, in units of the widest band's chip.
	function automatic logic [6:0] bw_mult(input logic [3:0] c);
		case (c)
			4'h0: bw_mult = 7'h40;
			4'h1: bw_mult = 7'h30;
			4'h2: bw_mult = 7'h20;
			4'h3: bw_mult = 7'h18;
			4'h4: bw_mult = 7'h10;
			4'h5: bw_mult = 7'h0c;
			4'h6: bw_mult = 7'h08;
			4'h7: bw_mult = 7'h04;
			4'h8: bw_mult = 7'h02;
			default: bw_mult = 7'h01;
		endcase
	endfunction

	// Channel width in hertz, whole channel rather than one sideband.
	function automatic logic [18:0] bw_hz(input logic [3:0] c);
		case (c)
			4'h0: bw_hz = 19'h01e84;
			4'h1: bw_hz = 19'h028b0;
			4'h2: bw_hz = 19'h03d09;
			4'h3: bw_hz = 19'h05161;
			4'h4: bw_hz = 19'h07a12;
			4'h5: bw_hz = 19'h0a2c2;
			4'h6: bw_hz = 19'h0f424;
			4'h7: bw_hz = 19'h1e848;
			4'h8: bw_hz = 19'h3d090;
			default: bw_hz = 19'h7a120;
		endcase
	endfunction

	// Bitwise CRC updates over one byte, most significant bit first.
	function automatic logic [7:0] crc8_byte(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ `CMPF_CRC8_POLY) : {r[6:0], 1'b0};
		end
		crc8_byte = r;
	endfunction

	function automatic logic [15:0] crc16_byte(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ `CMPF_CRC16_POLY)
				: {r[14:0], 1'b0};
		end
		crc16_byte = r;
	endfunction

	cmpf_spi_port port (
		.clock(clock),
		.reset(reset),
		.sck(sck),
		.nss_n(nss_n),
		.mosi(mosi),
		.miso(miso),
		.miso_oe_n(miso_oe_n),
		.wr_strobe(wr_strobe),
		.rd_strobe(rd_strobe),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	cmpf_pair_buffer out_buffer (
		.clock(clock),
		.reset(reset),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_data({push_kind, push_rate, push_data}),
		.out_valid(frame_valid),
		.out_ready(frame_ready),
		.out_data({frame_kind, frame_rate, frame_data})
	);

	// Effective settings; out-of-range codes clamp to the nearest limit.
	assign spread_on = op_mode[`CMPF_OP_SPREAD_BIT];
	assign headerless = setup_one[`CMPF_HEADERLESS_BIT];
	assign crc_on = setup_two[`CMPF_CRC_ON_BIT];
	assign bw_code = setup_one[`CMPF_BW_MSB:`CMPF_BW_LSB];
	assign sf_eff = (setup_two[`CMPF_SF_MSB:`CMPF_SF_LSB] < `CMPF_SF_MIN)
		? `CMPF_SF_MIN : (setup_two[`CMPF_SF_MSB:`CMPF_SF_LSB]
		> `CMPF_SF_MAX) ? `CMPF_SF_MAX
		: setup_two[`CMPF_SF_MSB:`CMPF_SF_LSB];
	assign chips = 13'h0001 << sf_eff;
	assign cr_eff = (setup_one[`CMPF_FEC_MSB:`CMPF_FEC_LSB] < `CMPF_FEC_MIN)
		? `CMPF_FEC_MIN : (setup_one[`CMPF_FEC_MSB:`CMPF_FEC_LSB]
		> `CMPF_FEC_MAX) ? `CMPF_FEC_MAX
		: setup_one[`CMPF_FEC_MSB:`CMPF_FEC_LSB];
	assign mult = bw_mult(bw_code);
	assign symbol_rate = 16'(bw_hz(bw_code) >> sf_eff);
	assign busy = state != st_idle;
	assign start = wr_strobe && reg_addr == `CMPF_ADDR_FRAME_CTRL
		&& wr_data[`CMPF_START_BIT] && spread_on && !busy;
	assign step = sym_due && buf_in_ready;

	// Register read mux; unmapped or hidden addresses read as zero.
	always_comb begin
		rd_data = 8'h00;
		if (reg_addr == `CMPF_ADDR_OP_MODE) begin
			rd_data = op_mode;
		end else if (spread_on && in_modem_map(reg_addr)) begin
			case (reg_addr)
				`CMPF_ADDR_FIFO: rd_data = mem[host_ptr];
				`CMPF_ADDR_SETUP_ONE: rd_data = setup_one;
				`CMPF_ADDR_SETUP_TWO: rd_data = setup_two;
				`CMPF_ADDR_PAYLOAD_LEN: rd_data = payload_len;
				`CMPF_ADDR_FRAME_CTRL: rd_data = {7'h00, busy};
				`CMPF_ADDR_RATE_HI: rd_data = symbol_rate[15:8];
				`CMPF_ADDR_RATE_LO: rd_data = symbol_rate[7:0];
				`CMPF_ADDR_FIFO_PTR: rd_data = host_ptr;
				`CMPF_ADDR_SF6_TUNING: rd_data = sf6_tuning;
				`CMPF_ADDR_SF6_THRESHOLD: rd_data = sf6_threshold;
				default: rd_data = 8'h00;
			endcase
		end
	end

	// Register writes; modem registers keep their contents, but writes
	// only land while the spread-mode map is selected.
	always_ff @(posedge clock) begin
		if (reset) begin
			op_mode <= `CMPF_RST_OP_MODE;
			setup_one <= `CMPF_RST_SETUP_ONE;
			setup_two <= `CMPF_RST_SETUP_TWO;
			payload_len <= `CMPF_RST_PAYLOAD_LEN;
			sf6_tuning <= `CMPF_RST_SF6_REG;
			sf6_threshold <= `CMPF_RST_SF6_REG;
			host_ptr <= 8'h00;
		end else if (wr_strobe && reg_addr == `CMPF_ADDR_OP_MODE) begin
			op_mode <= wr_data;
		end else if (wr_strobe && spread_on) begin
			case (reg_addr)
				`CMPF_ADDR_FIFO: host_ptr <= host_ptr + 8'h01;
				`CMPF_ADDR_SETUP_ONE: setup_one <= wr_data;
				`CMPF_ADDR_SETUP_TWO: setup_two <= wr_data;
				`CMPF_ADDR_PAYLOAD_LEN: payload_len <= wr_data;
				`CMPF_ADDR_FIFO_PTR: host_ptr <= wr_data;
				`CMPF_ADDR_SF6_TUNING: sf6_tuning <= wr_data;
				`CMPF_ADDR_SF6_THRESHOLD: sf6_threshold <= wr_data;
				default: host_ptr <= host_ptr;
			endcase
		end else if (rd_strobe && spread_on
			&& reg_addr == `CMPF_ADDR_FIFO) begin
			host_ptr <= host_ptr + 8'h01;
		end
	end

	// Host side of the data buffer; the framer reads the other port.
	always_ff @(posedge clock) begin
		if (wr_strobe && spread_on && reg_addr == `CMPF_ADDR_FIFO) begin
			mem[host_ptr] <= wr_data;
		end
	end

	// Chip and symbol pacing; compares use >= so a setting changed
	// mid-frame cannot strand a counter past its wrap.
	assign base_wrap = base_cnt >= CHIP_BASE_CYCLES - 8'h01;
	assign mult_wrap = mult_cnt >= mult - 7'h01;
	assign chip_wrap = chip_cnt >= chips - 13'h0001;
	assign sym_tick = busy && base_wrap && mult_wrap && chip_wrap;
	always_comb begin
		next_base_cnt = 8'h00;
		next_mult_cnt = 7'h00;
		next_chip_cnt = 13'h0000;
		if (busy) begin
			next_base_cnt = base_wrap ? 8'h00 : base_cnt + 8'h01;
			next_mult_cnt = mult_cnt;
			next_chip_cnt = chip_cnt;
			if (base_wrap) begin
				next_mult_cnt = mult_wrap ? 7'h00 : mult_cnt + 7'h01;
				if (mult_wrap) begin
					next_chip_cnt = chip_wrap ? 13'h0000
						: chip_cnt + 13'h0001;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			base_cnt <= 8'h00;
			mult_cnt <= 7'h00;
			chip_cnt <= 13'h0000;
		end else begin
			base_cnt <= next_base_cnt;
			mult_cnt <= next_mult_cnt;
			chip_cnt <= next_chip_cnt;
		end
	end

	// Framer: one word per symbol, held back while the buffer is full.
	always_comb begin
		after_header = (payload_len != 8'h00) ? st_payload
			: crc_on ? st_crc_hi : st_idle;
		next_state = state;
		next_cnt = cnt;
		next_rd_ptr = rd_ptr;
		next_crc = crc;
		next_sym_due = sym_tick ? 1'b1 : (step ? 1'b0 : sym_due);
		push = 1'b0;
		push_kind = kind_preamble;
		push_rate = cr_eff;
		push_data = 8'h00;
		case (state)
			st_idle: begin
				next_sym_due = 1'b0;
				if (start) begin
					next_state = st_preamble;
					next_cnt = 8'h00;
					next_rd_ptr = 8'h00;
					next_crc = 16'h0000;
				end
			end
			st_preamble: begin
				push = step;
				if (step) begin
					next_cnt = cnt + 8'h01;
					if (cnt == `CMPF_PREAMBLE_SYMBOLS - 8'h01) begin
						next_cnt = 8'h00;
						next_state = headerless ? after_header
							: st_header;
					end
				end
			end
			st_header: begin
				push = step;
				push_kind = kind_header;
				push_rate = `CMPF_HEADER_RATE;
				push_data = (cnt == 8'h00) ? payload_len
					: {crc_on, cr_eff, 4'h0};
				if (step) begin
					next_crc = {8'h00, crc8_byte(crc[7:0], push_data)};
					next_cnt = cnt + 8'h01;
					if (cnt == 8'h01) begin
						next_state = st_header_crc;
					end
				end
			end
			st_header_crc: begin
				push = step;
				push_kind = kind_crc;
				push_rate = `CMPF_HEADER_RATE;
				push_data = crc[7:0];
				if (step) begin
					next_crc = 16'h0000;
					next_state = after_header;
				end
			end
			st_payload: begin
				push = step;
				push_kind = kind_payload;
				push_data = mem[rd_ptr];
				if (step) begin
					next_crc = crc16_byte(crc, push_data);
					next_rd_ptr = rd_ptr + 8'h01;
					if (rd_ptr == payload_len - 8'h01) begin
						next_state = crc_on ? st_crc_hi : st_idle;
					end
				end
			end
			st_crc_hi: begin
				push = step;
				push_kind = kind_crc;
				push_data = crc[15:8];
				if (step) begin
					next_state = st_crc_lo;
				end
			end
			st_crc_lo: begin
				push = step;
				push_kind = kind_crc;
				push_data = crc[7:0];
				if (step) begin
					next_state = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= st_idle;
			cnt <= 8'h00;
			rd_ptr <= 8'h00;
			crc <= 16'h0000;
			sym_due <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rd_ptr <= next_rd_ptr;
			crc <= next_crc;
			sym_due <= next_sym_due;
		end
	end

	// Cycles since the last symbol, read only by the pacing check.
	logic [31:0] gap;
	always_ff @(posedge clock) begin
		gap <= (reset || !busy || sym_tick) ? 32'h0 : gap + 32'h1;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	chip_count_a: assert property (chips >= 13'h0040
		&& chips <= 13'h1000 && (chips & (chips - 13'h0001)) == 13'h0)
		else $error("Chips per symbol out of range.");
	fec_rate_map_a: assert property (push && push_kind == kind_payload
		|-> push_rate == cr_eff && push_rate >= 3'h1 && push_rate <= 3'h4)
		else $error("Payload rate code wrong.");
	header_rate_a: assert property (push && state == st_header_crc
		|-> push_rate == 3'h4 && push_data == crc[7:0])
		else $error("Header CRC word wrong.");
	header_fields_a: assert property (push && state == st_header
		|-> (cnt == 8'h00 && push_data == payload_len) || (cnt == 8'h01
		&& push_data[6:4] == cr_eff && push_data[7] == crc_on))
		else $error("Header fields wrong.");
	packet_order_a: assert property ($rose(state == st_payload)
		|-> $past(state) == st_header_crc || $past(state) == st_preamble)
		else $error("Payload entered out of order.");
	headerless_skip_a: assert property (state == st_preamble
		&& next_state != st_preamble && headerless
		|=> state != st_header)
		else $error("Header sent in headerless mode.");
	symbol_pace_a: assert property (sym_tick && $stable(setup_one)
		&& $stable(setup_two) && $past(sym_tick, 1) == 1'b0
		|-> gap + 32'h1 == 32'(CHIP_BASE_CYCLES) * 32'(mult) * 32'(chips))
		else $error("Symbol period wrong.");
	map_switch_a: assert property (wr_strobe && !spread_on
		&& reg_addr == `CMPF_ADDR_SETUP_ONE |=> $stable(setup_one))
		else $error("Modem register written outside spread mode.");
	fifo_write_a: assert property (wr_strobe && spread_on
		&& reg_addr == `CMPF_ADDR_FIFO
		|=> mem[$past(host_ptr)] == $past(wr_data)
		&& host_ptr == $past(host_ptr) + 8'h01)
		else $error("Data buffer write lost.");
	crc_after_a: assert property ($rose(state == st_crc_hi)
		|-> $past(state) == st_payload || $past(state) == st_header_crc
		|| $past(state) == st_preamble)
		else $error("Payload CRC out of place.");

	explicit_frame_c: cover property (state == st_header_crc && step);
	headerless_frame_c: cover property (state == st_preamble
		&& headerless && next_state == st_payload);
	crc_frame_c: cover property (state == st_crc_lo && step);
	stall_c: cover property (frame_valid && !frame_ready && sym_due);
endmodule

/* sim/cmpf_host_model.sv */
`timescale 1ns/10ps
module cmpf_host_model (
	input wire logic clock,
	input wire logic miso_line,
	output logic sck,
	output logic nss_n,
	output logic mosi
);
	// Deselected and clock low between accesses, as mode 0 wants.
	initial begin
		sck = 1'b0;
		nss_n = 1'b1;
		mosi = 1'b0;
	end
	// One two-byte access at the falling clock edge; each serial phase lasts
	// two clocks so the device sees every edge.
	task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
		nss_n = 1'b0;
		repeat (2) @(negedge clock);
		for (int i = 15; i >= 0; i--) begin
			mosi = tx[i];
			repeat (2) @(negedge clock);
			rx = {rx[6:0], miso_line};
			sck = 1'b1;
			repeat (2) @(negedge clock);
			sck = 1'b0;
		end
		repeat (2) @(negedge clock);
		nss_n = 1'b1;
		mosi = ~mosi; // A released line never keeps its last bit.
		repeat (3) @(negedge clock);
	endtask
endmodule

/* sim/test_chirp_modem_parameter_framing.sv */
`timescale 1ns/10ps
`include "cmpf_map.svh"
module test_chirp_modem_parameter_framing;
	import cmpf_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic sck, nss_n, mosi, miso, miso_oe_n, miso_line;
	logic frame_valid, frame_ready = 1'b1;
	logic [1:0] frame_kind;
	logic [2:0] frame_rate;
	logic [7:0] frame_data, rx;
	logic [15:0] c;
	logic [13:0] got[$], want[$], m;
	int stamp[$];
	int cyc = 0, hold = 0, error_cnt = 0, total_checks = 0;
	// Clock of 100 MHz.
	always #5 clock = ~clock;
	// A released data line shows the inverse, so no stale bit passes.
	assign miso_line = miso_oe_n ? ~miso : miso;
	cmpf_top #(.CHIP_BASE_CYCLES(8'h01)) cmpf_top_inst (.clock(clock),
		.reset(reset), .sck(sck), .nss_n(nss_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n), .frame_valid(frame_valid),
		.frame_ready(frame_ready), .frame_kind(frame_kind),
		.frame_rate(frame_rate), .frame_data(frame_data));
	cmpf_host_model cmpf_host_model_inst (.clock(clock),
		.miso_line(miso_line), .sck(sck), .nss_n(nss_n), .mosi(mosi));
	// Records each accepted word with its cycle number.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (frame_valid === 1'b1 && frame_ready) begin
			got.push_back({1'b0, frame_kind, frame_rate, frame_data});
			stamp.push_back(cyc);
		end
	end
	// One long stall after four words, long enough to fill the buffer.
	always @(negedge clock) begin
		frame_ready <= !(got.size() == 4 && hold < 300);
		if (got.size() == 4)
			hold <= hold + 1;
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		if (error_cnt == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		cmpf_host_model_inst.xfer({1'b1, a, d}, rx);
	endtask
	task rd(input logic [6:0] a, input logic [7:0] e);
		cmpf_host_model_inst.xfer({1'b0, a, 8'h00}, rx);
		check(16'(rx), 16'(e));
		check(16'(miso_oe_n), 16'h0001);
	endtask
	// Top bit of an expected word says whether its rate is compared.
	task push(input logic [13:0] w, input int n);
		repeat (n) want.push_back(w);
	endtask
	function automatic logic [15:0] crc(input logic [15:0] v,
		input logic [7:0] b, input logic [15:0] p, input int w);
		for (int i = 7; i >= 0; i--) begin
			v = (v[w - 1] ^ b[i]) ? ((v << 1) ^ p) : (v << 1);
		end
		return (w == 8) ? {8'h00, v[7:0]} : v;
	endfunction
	// Starts a frame and compares every word in order once all have come.
	task run_frame(input int period);
		got.delete();
		stamp.delete();
		hold = 0;
		wr(`CMPF_ADDR_FRAME_CTRL, 8'h01);
		rd(`CMPF_ADDR_FRAME_CTRL, 8'h01);
		for (int t = 0; t < 20000 && got.size() < want.size(); t++)
			@(negedge clock);
		// A short frame counts as one mismatch and skips the word compares.
		if (got.size() != want.size()) begin
			check(16'(got.size()), 16'(want.size()));
		end else begin
			check(16'(stamp[1] - stamp[0]), 16'(period));
			foreach (want[i]) begin
				m = want[i][13] ? 14'h1fff : 14'h18ff;
				check(16'(got[i] & m), 16'(want[i] & m));
			end
		end
		repeat (period) @(negedge clock);
		rd(`CMPF_ADDR_FRAME_CTRL, 8'h00);
		want.delete();
	endtask
	initial begin
		repeat (8) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		rd(`CMPF_ADDR_OP_MODE, 8'h00);
		wr(`CMPF_ADDR_SETUP_ONE, 8'h11);
		rd(`CMPF_ADDR_SETUP_ONE, 8'h00);
		wr(`CMPF_ADDR_OP_MODE, 8'h80);
		rd(`CMPF_ADDR_SETUP_ONE, 8'h72);
		rd(`CMPF_ADDR_SETUP_TWO, 8'h70);
		rd(7'h20, 8'h00);
		rd(`CMPF_ADDR_RATE_HI, 8'h03);
		rd(`CMPF_ADDR_RATE_LO, 8'hd0);
		rd(`CMPF_ADDR_SF6_TUNING, 8'h00);
		rd(`CMPF_ADDR_SF6_THRESHOLD, 8'h00);
		// Factor 6 with its tuning writes, headerless, 500 kHz (high band).
		wr(`CMPF_ADDR_SF6_TUNING, 8'h05);
		wr(`CMPF_ADDR_SF6_THRESHOLD, 8'h0c);
		rd(`CMPF_ADDR_SF6_TUNING, 8'h05);
		rd(`CMPF_ADDR_SF6_THRESHOLD, 8'h0c);
		wr(`CMPF_ADDR_SETUP_TWO, 8'h64);
		wr(`CMPF_ADDR_SETUP_ONE, 8'h95);
		rd(`CMPF_ADDR_RATE_HI, 8'h1e);
		rd(`CMPF_ADDR_RATE_LO, 8'h84);
		wr(`CMPF_ADDR_PAYLOAD_LEN, 8'h02);
		wr(`CMPF_ADDR_FIFO_PTR, 8'h00);
		wr(`CMPF_ADDR_FIFO, 8'ha5);
		wr(`CMPF_ADDR_FIFO, 8'h3c);
		rd(`CMPF_ADDR_FIFO_PTR, 8'h02);
		wr(`CMPF_ADDR_FIFO_PTR, 8'h00);
		rd(`CMPF_ADDR_FIFO, 8'ha5);
		c = crc(crc(16'h0000, 8'ha5, 16'h1021, 16), 8'h3c, 16'h1021, 16);
		push({1'b1, 2'h0, 3'h2, 8'h00}, 12);
		push({1'b1, 2'h2, 3'h2, 8'ha5}, 1);
		push({1'b1, 2'h2, 3'h2, 8'h3c}, 1);
		push({1'b0, 2'h3, 3'h0, c[15:8]}, 1);
		push({1'b0, 2'h3, 3'h0, c[7:0]}, 1);
		run_frame(64);
		// Largest factor and narrowest band show in the rate.
		wr(`CMPF_ADDR_SETUP_TWO, 8'hc0);
		rd(`CMPF_ADDR_RATE_LO, 8'h7a);
		wr(`CMPF_ADDR_SETUP_ONE, 8'h00);
		rd(`CMPF_ADDR_RATE_LO, 8'h01);
		// Then an explicit frame.
		wr(`CMPF_ADDR_SETUP_TWO, 8'h70);
		wr(`CMPF_ADDR_SETUP_ONE, 8'h96);
		wr(`CMPF_ADDR_PAYLOAD_LEN, 8'h01);
		wr(`CMPF_ADDR_FIFO_PTR, 8'h00);
		wr(`CMPF_ADDR_FIFO, 8'h5a);
		c = crc(crc(16'h0000, 8'h01, 16'h0007, 8), 8'h30, 16'h0007, 8);
		push({1'b1, 2'h0, 3'h3, 8'h00}, 12);
		push({1'b1, 2'h1, 3'h4, 8'h01}, 1);
		push({1'b1, 2'h1, 3'h4, 8'h30}, 1);
		push({1'b1, 2'h3, 3'h4, c[7:0]}, 1);
		push({1'b1, 2'h2, 3'h3, 8'h5a}, 1);
		run_frame(128);
		results();
	end
endmodule
